// ### verilog/mcu_exec_defines.vh
// Constants for the instruction decode and execution-control block
`ifndef MCU_EXEC_DEFINES_VH
`define MCU_EXEC_DEFINES_VH

// AXI4-Lite register byte offsets
`define REG_CTRL     8'h00
`define REG_STATUS   8'h04
`define REG_ACC      8'h08
`define REG_PC       8'h0C
`define REG_TABLE_HIGH 8'h10
`define REG_PADDR    8'h14
`define REG_PDATA    8'h18
`define REG_DADDR    8'h1C
`define REG_DDATA    8'h20

// AXI responses
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

// Register field positions
`define CTRL_RUN     0
`define STAT_HALT    8
`define FLAG_C       0
`define FLAG_AUX     1
`define FLAG_Z       2
`define FLAG_OVF     3
`define FLAG_PWRDN   4
`define FLAG_TIMEOUT 5

// Data memory addresses with special meaning
`define DADDR_PC_LOW     7'h02
`define DADDR_TABLE_HIGH 7'h03
`define DADDR_STATUS 7'h0A

// Last clock phase of a four-clock instruction cycle
`define PHASE_LAST   2'h3

// Paired opcodes: op = {fn, dest}, dest 0 = accumulator, 1 = data memory
`define FN_ADD   5'h00
`define FN_ADC   5'h01
`define FN_SUB   5'h02
`define FN_SBC   5'h03
`define FN_AND   5'h04
`define FN_OR    5'h05
`define FN_XOR   5'h06
`define FN_CPL   5'h07
`define FN_INC   5'h08
`define FN_DEC   5'h09
`define FN_RR    5'h0A
`define FN_RRC   5'h0B
`define FN_RL    5'h0C
`define FN_RLC   5'h0D
`define FN_SWAP  5'h0E
`define FN_SZ    5'h0F
`define FN_SIZ   5'h10
`define FN_SDZ   5'h11
`define OP_PAIR_END 6'h24

// Single opcodes
`define OP_ADDI   6'h24
`define OP_SUBI   6'h25
`define OP_ANDI   6'h26
`define OP_ORI    6'h27
`define OP_XORI   6'h28
`define OP_MOVI   6'h29
`define OP_MOVAM  6'h2A
`define OP_MOVMA  6'h2B
`define OP_DEC_ADJ 6'h2C
`define OP_CLRB   6'h2D
`define OP_SETB   6'h2E
`define OP_SZB    6'h2F
`define OP_SNZB   6'h30
`define OP_JMP    6'h31
`define OP_CALL   6'h32
`define OP_RET    6'h33
`define OP_RETA   6'h34
`define OP_RET_INT 6'h35
`define OP_TRDC   6'h36
`define OP_TRDL   6'h37
`define OP_NOP    6'h38
`define OP_CLRM   6'h39
`define OP_SETM   6'h3A
`define OP_CLRWDT 6'h3B
`define OP_WDT1   6'h3C
`define OP_WDT2   6'h3D
`define OP_HALT   6'h3E

`endif

// ### verilog/mcu_instruction_execute_timing.v
// Accumulator core execute unit with its memories and an AXI4-Lite slave
`include "mcu_exec_defines.vh"

// Summary of operation
// - Bit operand picks one of bits 0 to 7 of the addressed byte.
// - Add, with or without carry, to ACC or memory; sets zero, carry, aux carry, overflow.
// - Subtract, with or without borrow, one cycle; sets zero, carry, aux carry, overflow.
// - Decimal adjust writes ACC result to memory in one cycle; only C changes.
// - AND, OR, XOR and complement take one cycle and change only Z.
// - Increment and decrement take one cycle and change only Z.
// - Plain rotates take one cycle and change no flag.
// - Rotates through carry move carry into the path and update it.
// - Moves between memory, ACC and immediate take one cycle, no flags.
// - Set or clear one memory bit in one cycle, nothing else changes.
// - Skips test byte zero, bit state, or incremented or decremented byte.
// - Accumulator skip variants write ACC and leave memory unchanged.
// - Taken skip costs two cycles, untaken skip one.
// - Any write to the program counter low byte costs two cycles.
// - Call and return each take two cycles and change no flags.
// - Return with immediate loads ACC, two cycles, no flags.
// - Return from interrupt takes two cycles, no flags.
// - Table read of current page: high part to table high, low to memory.
// - Table read of last page, same split, two cycles.
// - Nibble swap to memory or ACC in one cycle, no flags.
// - Single watchdog clear takes one cycle, clears time-out and power-down.
// - Paired watchdog clear acts only when both halves run in succession.
// - One instruction cycle lasts four clocks.
// - Halt stops execution, clears watchdog, sets power-down, clears time-out.
// - Decimal adjust adds six to a nibble above nine or with carry.
// - Repeating one watchdog half without the other does nothing.
module mcu_instruction_execute_timing #(
  parameter PC_W        = 10,
  parameter STACK_DEPTH = 8,
  parameter SP_W        = 3,
  parameter WDT_PERIOD  = 1024
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready
);

  localparam HALF_NONE = 3'b001;
  localparam HALF_ONE  = 3'b010;
  localparam HALF_TWO  = 3'b100;

  // Memories
  reg [15:0]     pmem [0:(1<<PC_W)-1];
  reg [7:0]      dmem [0:127];
  reg [PC_W-1:0] stack [0:STACK_DEPTH-1];

  // Core state
  reg [7:0]      acc;
  reg            c_flag;
  reg            aux_carry_flag;
  reg            z_flag;
  reg            overflow_flag;
  reg            powerdown_flag;
  reg            watchdog_timeout_flag;
  reg [7:0]      table_high_byte;
  reg [PC_W-1:0] pc;
  reg [15:0]     ir;
  reg            ir_valid;
  reg [1:0]      phase;
  reg            run;
  reg            halted;
  reg [SP_W-1:0] sp;
  reg [15:0]     wdt_cnt;
  reg [2:0]      wdt_half;

  // Bus-side state
  reg [7:0]      aw_addr;
  reg [31:0]     w_data;
  reg [3:0]      w_strb;
  reg [PC_W-1:0] paddr;
  reg [6:0]      daddr;

  // Instruction fields
  wire [5:0]      op      = ir[15:10];
  wire [2:0]      bit_sel = ir[9:7];
  wire [6:0]      m_addr  = ir[6:0];
  wire [7:0]      imm     = ir[7:0];
  wire [PC_W-1:0] jaddr   = ir[PC_W-1:0];
  wire [PC_W-1:0] cur_pc  = pc - {{(PC_W-1){1'b0}}, 1'b1};
  wire            step    = run && !halted && (phase == `PHASE_LAST);
  wire            wdt_exp = step && (wdt_cnt == WDT_PERIOD[15:0] - 16'h0001);

  // Flag byte and status word
  reg [5:0]  flags;
  reg [31:0] status_word;
  always @* begin
    flags                 = 6'h00;
    flags[`FLAG_C]        = c_flag;
    flags[`FLAG_AUX]      = aux_carry_flag;
    flags[`FLAG_Z]        = z_flag;
    flags[`FLAG_OVF]      = overflow_flag;
    flags[`FLAG_PWRDN]    = powerdown_flag;
    flags[`FLAG_TIMEOUT]  = watchdog_timeout_flag;
    status_word           = {26'h0000000, flags};
    status_word[`STAT_HALT] = halted;
  end

  // Operand byte, with special addresses mapped onto core state
  reg [7:0] md;
  always @* begin
    case (m_addr)
      `DADDR_PC_LOW:     md = cur_pc[7:0];
      `DADDR_TABLE_HIGH: md = table_high_byte;
      `DADDR_STATUS: md = {2'b00, flags};
      default:       md = dmem[m_addr];
    endcase
  end

  // Table read address: current page or last page, low byte from ACC
  wire [PC_W-1:0] tbl_addr = (op == `OP_TRDL) ? {{(PC_W-8){1'b1}}, acc} :
                                                {cur_pc[PC_W-1:8], acc};
  wire [15:0]     tbl_word = pmem[tbl_addr];

  // Decode and execute datapath
  reg [4:0]      fn;
  reg            to_mem;
  reg            is_alu;
  reg            no_wb;
  reg            skip;
  reg [7:0]      b;
  reg [7:0]      bb;
  reg            ci;
  reg [8:0]      sum9;
  reg [4:0]      nib;
  reg [8:0]      daa_t;
  reg            hi_adj;
  reg [7:0]      res;
  reg [7:0]      next_acc;
  reg            next_c;
  reg            next_aux;
  reg            next_z;
  reg            next_ovf;
  reg            mem_we;
  reg [7:0]      mem_wd;
  reg            redirect;
  reg [PC_W-1:0] target;
  reg            push;
  reg            pop;
  reg            table_high_byte_we;
  reg            go_halt;
  reg            wdt_clr;
  reg [2:0]      next_half;
  always @* begin
    fn        = op[5:1];
    to_mem    = op[0];
    is_alu    = (op < `OP_PAIR_END);
    no_wb     = 1'b0;
    skip      = 1'b0;
    b         = md;
    res       = md;
    next_acc  = acc;
    next_c    = c_flag;
    next_aux  = aux_carry_flag;
    next_z    = z_flag;
    next_ovf  = overflow_flag;
    mem_we    = 1'b0;
    mem_wd    = 8'h00;
    redirect  = 1'b0;
    target    = pc;
    push      = 1'b0;
    pop       = 1'b0;
    table_high_byte_we   = 1'b0;
    go_halt   = 1'b0;
    wdt_clr   = 1'b0;
    next_half = HALF_NONE;
    // Immediate forms reuse the accumulator datapath
    case (op)
      `OP_ADDI: begin fn = `FN_ADD; to_mem = 1'b0; b = imm; is_alu = 1'b1; end
      `OP_SUBI: begin fn = `FN_SUB; to_mem = 1'b0; b = imm; is_alu = 1'b1; end
      `OP_ANDI: begin fn = `FN_AND; to_mem = 1'b0; b = imm; is_alu = 1'b1; end
      `OP_ORI:  begin fn = `FN_OR;  to_mem = 1'b0; b = imm; is_alu = 1'b1; end
      `OP_XORI: begin fn = `FN_XOR; to_mem = 1'b0; b = imm; is_alu = 1'b1; end
      default: ;
    endcase
    // Shared adder: subtraction adds the complement, carry means no borrow
    bb    = (fn == `FN_SUB || fn == `FN_SBC) ? ~b : b;
    ci    = (fn == `FN_SUB) ? 1'b1 : ((fn == `FN_ADC || fn == `FN_SBC) ? c_flag : 1'b0);
    sum9  = {1'b0, acc} + {1'b0, bb} + {8'h00, ci};
    nib   = {1'b0, acc[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    daa_t = {1'b0, acc} + (((acc[3:0] > 4'h9) || aux_carry_flag) ? 9'h006 : 9'h000);
    hi_adj = daa_t[8] || (daa_t[7:4] > 4'h9) || c_flag;
    if (is_alu) begin
      case (fn)
        `FN_ADD, `FN_ADC, `FN_SUB, `FN_SBC: begin
          res     = sum9[7:0];
          next_c  = sum9[8];
          next_aux = nib[4];
          next_ovf = (acc[7] == bb[7]) && (sum9[7] != acc[7]);
          next_z  = (sum9[7:0] == 8'h00);
        end
        `FN_AND:  begin res = acc & b; next_z = ((acc & b) == 8'h00); end
        `FN_OR:   begin res = acc | b; next_z = ((acc | b) == 8'h00); end
        `FN_XOR:  begin res = acc ^ b; next_z = ((acc ^ b) == 8'h00); end
        `FN_CPL:  begin res = ~b; next_z = (b == 8'hFF); end
        `FN_INC:  begin res = b + 8'h01; next_z = (b == 8'hFF); end
        `FN_DEC:  begin res = b - 8'h01; next_z = (b == 8'h01); end
        `FN_RR:   res = {b[0], b[7:1]};
        `FN_RL:   res = {b[6:0], b[7]};
        `FN_RRC:  begin res = {c_flag, b[7:1]}; next_c = b[0]; end
        `FN_RLC:  begin res = {b[6:0], c_flag}; next_c = b[7]; end
        `FN_SWAP: res = {b[3:0], b[7:4]};
        `FN_SZ:   begin res = b; no_wb = 1'b1; skip = (b == 8'h00); end
        `FN_SIZ:  begin res = b + 8'h01; skip = (b == 8'hFF); end
        `FN_SDZ:  begin res = b - 8'h01; skip = (b == 8'h01); end
        default:  no_wb = 1'b1;
      endcase
      // Memory form writes the byte unless no_wb is set, ACC form leaves memory alone
      if (!to_mem) begin
        next_acc = res;
      end else if (!no_wb) begin
        mem_we = 1'b1;
        mem_wd = res;
      end
    end else begin
      case (op)
        `OP_MOVI:  next_acc = imm;
        `OP_MOVAM: next_acc = md;
        `OP_MOVMA: begin mem_we = 1'b1; mem_wd = acc; end
        `OP_DEC_ADJ: begin
          mem_we = 1'b1;
          mem_wd = daa_t[7:0] + (hi_adj ? 8'h60 : 8'h00);
          next_c = hi_adj;
        end
        `OP_CLRB:  begin mem_we = 1'b1; mem_wd = md & ~(8'h01 << bit_sel); end
        `OP_SETB:  begin mem_we = 1'b1; mem_wd = md | (8'h01 << bit_sel); end
        `OP_SZB:   skip = ~md[bit_sel];
        `OP_SNZB:  skip = md[bit_sel];
        `OP_JMP:   begin redirect = 1'b1; target = jaddr; end
        `OP_CALL:  begin push = 1'b1; redirect = 1'b1; target = jaddr; end
        `OP_RET, `OP_RET_INT: begin
          pop = 1'b1;
          redirect = 1'b1;
          target = stack[sp - {{(SP_W-1){1'b0}}, 1'b1}];
        end
        `OP_RETA: begin
          pop = 1'b1;
          redirect = 1'b1;
          target = stack[sp - {{(SP_W-1){1'b0}}, 1'b1}];
          next_acc = imm;
        end
        `OP_TRDC, `OP_TRDL: begin
          table_high_byte_we = 1'b1;
          mem_we = 1'b1;
          mem_wd = tbl_word[7:0];
          redirect = 1'b1;
        end
        `OP_CLRM:   begin mem_we = 1'b1; mem_wd = 8'h00; end
        `OP_SETM:   begin mem_we = 1'b1; mem_wd = 8'hFF; end
        `OP_CLRWDT: wdt_clr = 1'b1;
        `OP_WDT1: begin
          if (wdt_half == HALF_TWO) wdt_clr = 1'b1;
          else next_half = HALF_ONE;
        end
        `OP_WDT2: begin
          if (wdt_half == HALF_ONE) wdt_clr = 1'b1;
          else next_half = HALF_TWO;
        end
        `OP_HALT:   go_halt = 1'b1;
        default: ;
      endcase
    end
    // A taken skip jumps over the instruction already fetched
    if (skip) begin
      redirect = 1'b1;
      target = pc + {{(PC_W-1){1'b0}}, 1'b1};
    end
    // Writing the low program counter byte is a jump within the page
    if (mem_we && m_addr == `DADDR_PC_LOW) begin
      redirect = 1'b1;
      target = {cur_pc[PC_W-1:8], mem_wd};
    end
  end

  // Core sequencing, memories and register bus
  always @(posedge aclk) begin
    if (!aresetn) begin
      acc <= 8'h00;
      c_flag <= 1'b0;
      aux_carry_flag <= 1'b0;
      z_flag <= 1'b0;
      overflow_flag <= 1'b0;
      powerdown_flag <= 1'b0;
      watchdog_timeout_flag <= 1'b0;
      table_high_byte <= 8'h00;
      pc <= {PC_W{1'b0}};
      ir <= 16'h0000;
      ir_valid <= 1'b0;
      phase <= 2'h0;
      run <= 1'b0;
      halted <= 1'b0;
      sp <= {SP_W{1'b0}};
      wdt_cnt <= 16'h0000;
      wdt_half <= HALF_NONE;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      paddr <= {PC_W{1'b0}};
      daddr <= 7'h00;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rresp <= `RESP_OKAY;
      rdata <= 32'h00000000;
    end else begin
      // Four clock phases per instruction cycle; halt freezes them
      if (run && !halted) phase <= phase + 2'h1;
      // Watchdog: expiry sets time-out even if a clear lands in that cycle
      if (step) begin
        wdt_cnt <= (wdt_exp || (ir_valid && (wdt_clr || go_halt))) ? 16'h0000 : wdt_cnt + 16'h0001;
        watchdog_timeout_flag <= wdt_exp ||
                                 (watchdog_timeout_flag && !(ir_valid && (wdt_clr || go_halt)));
      end
      if (step && !ir_valid) begin
        // Idle cycle after a redirect: refill the fetch slot
        ir <= pmem[pc];
        pc <= pc + {{(PC_W-1){1'b0}}, 1'b1};
        ir_valid <= 1'b1;
      end else if (step) begin
        acc <= next_acc;
        c_flag <= next_c;
        aux_carry_flag <= next_aux;
        z_flag <= next_z;
        overflow_flag <= next_ovf;
        wdt_half <= next_half;
        if (wdt_clr) powerdown_flag <= 1'b0;
        if (go_halt) begin
          powerdown_flag <= 1'b1;
          halted <= 1'b1;
        end
        if (mem_we) dmem[m_addr] <= mem_wd;
        if (table_high_byte_we) table_high_byte <= tbl_word[15:8];
        if (push) begin
          stack[sp] <= pc;
          sp <= sp + {{(SP_W-1){1'b0}}, 1'b1};
        end
        if (pop) sp <= sp - {{(SP_W-1){1'b0}}, 1'b1};
        if (redirect) begin
          pc <= target;
          ir_valid <= 1'b0;
        end else begin
          ir <= pmem[pc];
          pc <= pc + {{(PC_W-1){1'b0}}, 1'b1};
        end
      end
      // Write address and data are taken independently
      if (awvalid && awready) begin
        aw_addr <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data <= wdata;
        w_strb <= wstrb;
        wready <= 1'b0;
      end
      // Both halves held: perform the write and answer
      if (!awready && !wready && !bvalid) begin
        bvalid <= 1'b1;
        bresp <= `RESP_OKAY;
        case (aw_addr)
          `REG_CTRL: if (w_strb[0]) begin
            run <= w_data[`CTRL_RUN];
            if (w_data[`CTRL_RUN]) halted <= 1'b0;
          end
          `REG_PADDR: begin
            if (w_strb[0]) paddr[7:0] <= w_data[7:0];
            if (w_strb[1]) paddr[PC_W-1:8] <= w_data[PC_W-1:8];
          end
          `REG_PDATA: pmem[paddr] <= {w_strb[1] ? w_data[15:8] : pmem[paddr][15:8],
                                      w_strb[0] ? w_data[7:0] : pmem[paddr][7:0]};
          `REG_DADDR: if (w_strb[0]) daddr <= w_data[6:0];
          `REG_DDATA: if (w_strb[0]) dmem[daddr] <= w_data[7:0];
          `REG_STATUS, `REG_ACC, `REG_PC, `REG_TABLE_HIGH: ;
          default: bresp <= `RESP_SLVERR;
        endcase
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
      // Read channel: answer one cycle after the address is taken
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= `RESP_OKAY;
        case (araddr)
          `REG_CTRL:   rdata <= {31'h00000000, run};
          `REG_STATUS: rdata <= status_word;
          `REG_ACC:    rdata <= {24'h000000, acc};
          `REG_PC:     rdata <= {{(32-PC_W){1'b0}}, cur_pc};
          `REG_TABLE_HIGH: rdata <= {24'h000000, table_high_byte};
          `REG_PADDR:  rdata <= {{(32-PC_W){1'b0}}, paddr};
          `REG_PDATA:  rdata <= {16'h0000, pmem[paddr]};
          `REG_DADDR:  rdata <= {25'h0000000, daddr};
          `REG_DDATA:  rdata <= {24'h000000, dmem[daddr]};
          default: begin
            rdata <= 32'h00000000;
            rresp <= `RESP_SLVERR;
          end
        endcase
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule // mcu_instruction_execute_timing

// ### testbench/mcu_exec_chk_sva.sv
// Bus-side assertions for the execute unit register interface
module mcu_exec_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [1:0]  rresp,
  input wire logic [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Read answers one cycle after the request, write one cycle after the held halves
  chk_write_answer: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
    else $error("write response missing");
  chk_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data missing");
  // Answers stand unchanged until accepted
  chk_bresp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  chk_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  // No new request taken while an answer is pending
  chk_aw_blocked: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while busy");
  chk_ar_blocked: assert property (rvalid |-> !arready)
    else $error("read accepted while busy");
  // Write readies return right after the answer is taken; arready is checked two cycles later while rvalid stays low
  chk_ready_back: assert property (bvalid && bready |=> awready && wready && !bvalid)
    else $error("write readies not restored");
  chk_rready_back: assert property (rvalid && rready ##1 !rvalid [*2] |-> arready)
    else $error("read ready not restored");
  // Reset clears both answers
  chk_reset_idle: assert property (disable iff (1'b0) !aresetn |=> !bvalid && !rvalid)
    else $error("answer pending after reset");
  cov_write: cover property (bvalid && bready);
  cov_read: cover property (rvalid && rready);
  cov_err: cover property (rvalid && rresp == 2'h2);
endmodule // mcu_exec_chk

bind mcu_instruction_execute_timing mcu_exec_chk chk (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .rready(rready), .rresp(rresp), .rdata(rdata)
);

// ### testbench/axil_master_model.sv
// Register bus master standing on the far side of the execute unit
module axil_master_model (
  input  wire logic        aclk,
  output logic [7:0]  awaddr = 8'h00,
  output logic        awvalid = 1'b0,
  output logic [31:0] wdata = 32'h0,
  output logic [3:0]  wstrb = 4'h3,
  output logic        wvalid = 1'b0,
  input  wire logic        awready,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic        bready = 1'b0,
  output logic [7:0]  araddr = 8'h00,
  output logic        arvalid = 1'b0,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic        rready = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // One write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
  endtask
  // One read: response taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        break;
      end
    end
    rready <= 1'b0;
  endtask
endmodule // axil_master_model

// ### testbench/tb_mcu_instruction_execute_timing.sv
// Self-checking bench running small programs through the execute unit
`include "mcu_exec_defines.vh"
module tb_mcu_instruction_execute_timing;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  wire [7:0] awaddr, araddr;
  wire [31:0] wdata, rdata;
  wire [3:0] wstrb;
  wire [1:0] bresp, rresp;
  wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] d;
  logic [1:0] r;
  // Program: arithmetic, bit set, skip, watchdog pairs, then BCD, rotate, call and table read
  logic [15:0] prog [32] = '{16'hA47F, 16'h9001, 16'hAC10, 16'hB990, 16'h8411, 16'hA455, 16'hA008, 16'hF800,
                             16'hF000, 16'hF000, 16'hA80A, 16'hAC12, 16'hF000, 16'hF400, 16'hA80A, 16'hF800,
                             16'hA438, 16'h9029, 16'hB013, 16'h9470, 16'h5813, 16'h7413, 16'hC81E, 16'hAC14,
                             16'hF800, 16'hE000, 16'hE000, 16'hE000, 16'hE000, 16'hE000, 16'hDC15, 16'hD044};
  always #20 aclk = ~aclk;
  mcu_instruction_execute_timing #(.WDT_PERIOD(8)) uut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  axil_master_model m (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .awready(awready), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  // Compare a seen value with the expected one
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    m.rd(a, d, r);
    check({30'h0, r}, {30'h0, `RESP_OKAY});
    check(d, exp);
  endtask
  task automatic mem_rd(input logic [6:0] a, input logic [31:0] exp);
    m.wr(`REG_DADDR, {25'h0, a});
    rd_chk(`REG_DDATA, exp);
  endtask
  task automatic finish_test;
    $display("errors=%0d checks=%0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Cycle ceiling against a hung handshake
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(`REG_STATUS, 32'h0);
    m.rd(8'h30, d, r);
    check({30'h0, r}, {30'h0, `RESP_SLVERR});
    check(d, 32'h0);
    m.wr(8'h30, 32'h0);
    check({30'h0, bresp}, {30'h0, `RESP_SLVERR});
    m.wr(`REG_DADDR, 32'h11);
    check({30'h0, bresp}, {30'h0, `RESP_OKAY});
    m.wr(`REG_DDATA, 32'hFF);
    for (int i = 0; i < 32; i++) begin
      m.wr(`REG_PADDR, i);
      m.wr(`REG_PDATA, {16'h0, prog[i]});
    end
    // Table word in the last page, fetched with ACC as the low address
    m.wr(`REG_PADDR, 32'h333);
    m.wr(`REG_PDATA, 32'hBEEF);
    // First run: add overflow, bit set, taken skip, xor, halt
    m.wr(`REG_CTRL, 32'h1);
    repeat (200) @(posedge aclk);
    rd_chk(`REG_STATUS, 32'h11A);
    rd_chk(`REG_ACC, 32'h88);
    mem_rd(7'h10, 32'h88);
    mem_rd(7'h11, 32'h00);
    // Second run: repeated first half, then an alternating pair
    m.wr(`REG_CTRL, 32'h1);
    repeat (200) @(posedge aclk);
    mem_rd(7'h12, 32'h1A);
    rd_chk(`REG_ACC, 32'h0A);
    // Third run: BCD adjust, subtract, rotate through carry, swap, call, table read, return with value
    m.wr(`REG_CTRL, 32'h1);
    repeat (200) @(posedge aclk);
    rd_chk(`REG_STATUS, 32'h113);
    rd_chk(`REG_ACC, 32'h44);
    rd_chk(`REG_TABLE_HIGH, 32'hBE);
    mem_rd(7'h13, 32'h76);
    mem_rd(7'h14, 32'h44);
    mem_rd(7'h15, 32'hEF);
    finish_test();
  end
endmodule // tb_mcu_instruction_execute_timing
